// ==== rtl/dcpd_clk_sel.v ====
// glitch-free selector between the main and real-time oscillator levels
`timescale 1ns/10ps
module dcpd_clk_sel
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // oscillator levels, already synchronised
    input wire i_main_lvl,
    input wire i_rtc_lvl,
    input wire i_main_en,
    input wire i_sel_rtc,
    // selected clock and active source
    output reg o_clk,
    output reg o_src_rtc
);

reg parked_r;
wire cur_lvl;
wire new_lvl;

assign cur_lvl = o_src_rtc ? i_rtc_lvl : (i_main_lvl & i_main_en);
assign new_lvl = i_sel_rtc ? i_rtc_lvl : (i_main_lvl & i_main_en);

// ==================================================================
// leave the old source only while it is low, join the new one only while
// it is low, so no shortened high or low phase reaches the core
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        parked_r <= 1'b0;
        o_src_rtc <= 1'b0;
        o_clk <= 1'b0;
    end
    else if (parked_r)
    begin
        o_clk <= 1'b0;
        if (!new_lvl)
        begin
            o_src_rtc <= i_sel_rtc;
            parked_r <= 1'b0;
        end
    end
    else if ((i_sel_rtc != o_src_rtc) && !cur_lvl)
    begin
        parked_r <= 1'b1;
        o_clk <= 1'b0;
    end
    else
    begin
        o_clk <= cur_lvl;
    end
end

endmodule // dcpd_clk_sel

// ==== rtl/dcpd_regs.vh ====
// register map, field positions, reset values and counts of the clock and power-down control
`ifndef DCPD_REGS_VH
`define DCPD_REGS_VH

// ==================================================================
// register byte offsets
`define DCPD_OFS_MODE     12'h000
`define DCPD_OFS_STATUS   12'h004
`define DCPD_OFS_IRQ_STAT 12'h008
`define DCPD_OFS_IRQ_MASK 12'h00c
`define DCPD_OFS_WDT_CNT  12'h010

// ==================================================================
// mode register fields
`define DCPD_MODE_SLOW_BIT  0
`define DCPD_MODE_QOFF_BIT  1
`define DCPD_MODE_RST       2'h0

// ==================================================================
// status register fields
`define DCPD_ST_PDF_BIT     0
`define DCPD_ST_TO_BIT      1
`define DCPD_ST_HALT_BIT    2
`define DCPD_ST_WAKE_BIT    3
`define DCPD_ST_SRC_BIT     4
`define DCPD_ST_RCMODE_BIT  5
`define DCPD_ST_WDTEN_BIT   6
`define DCPD_ST_WDTOWN_BIT  7

// ==================================================================
// interrupt event bits, shared by status and mask
`define DCPD_IRQ_SLEEP_BIT  0
`define DCPD_IRQ_WAKE_BIT   1
`define DCPD_IRQ_WDT_BIT    2
`define DCPD_IRQ_W          3
`define DCPD_IRQ_RST        3'h0

// ==================================================================
// timing counts
`define DCPD_WAKE_SYS_CLKS  1024
`define DCPD_WDT_BITS       14
`define DCPD_CFG_SETTLE     2'h3

`endif

// ==== rtl/dcpd_sync2.v ====
// two-flop synchroniser for a vector of unrelated pin levels
`timescale 1ns/10ps
module dcpd_sync2
#(
    parameter W = 1
)
(
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // pins and synchronised levels
    input wire [W-1:0] i_async,
    output reg [W-1:0] o_sync
);

reg [W-1:0] meta_r;

// ==================================================================
// first stage feeds only the second stage
always @(posedge i_clk or posedge i_rst)
begin
    if (i_rst)
    begin
        meta_r <= {W{1'b0}};
        o_sync <= {W{1'b0}};
    end
    else
    begin
        meta_r <= i_async;
        o_sync <= meta_r;
    end
end

endmodule // dcpd_sync2

// ==== rtl/dcpd_top.v ====
// dual clock selection, watchdog and power-down control with an AHB-Lite register port
`timescale 1ns/10ps
`include "dcpd_regs.vh"
module dcpd_top
#(
    parameter WDT_BITS = `DCPD_WDT_BITS,
    parameter WAKE_CLKS = `DCPD_WAKE_SYS_CLKS
)
(
    // clock and reset
    input wire I_SYS_CLK,
    input wire I_RST,
    // ahb-lite slave
    input wire I_HSEL,
    input wire [11:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [2:0] I_HSIZE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    output reg [31:0] O_HRDATA,
    output reg O_HREADYOUT,
    output reg O_HRESP,
    // oscillator pins and configuration options
    input wire I_MAIN_OSC_IN_PIN,
    input wire I_PORT_A_BIT6,
    input wire I_RTC_XTAL_IN_PIN,
    input wire I_WDT_OSC,
    input wire I_CFG_RC_MODE,
    input wire I_CFG_WDT_EN,
    input wire I_CFG_WDT_OWN_OSC,
    output reg O_MAIN_OSC_EN,
    output reg O_RTC_OSC_EN,
    output reg O_RTC_QUICK_START,
    output reg O_WDT_OSC_EN,
    output reg O_PORT_A_BIT6_IS_OSC,
    output reg O_PORT_A_BIT5_IS_GPIO,
    // processor core
    input wire I_SLEEP_EXEC,
    input wire I_WAKE_REQ,
    input wire I_CLR_WDT,
    output reg O_CORE_CLK,
    output reg O_CORE_HALT,
    output reg O_HOLD_STATE,
    output reg O_WDT_RESET,
    output reg O_POWER_DOWN_FLAG,
    output reg O_WATCHDOG_TIMEOUT_FLAG,
    output reg O_IRQ
);

// ==================================================================
// power state machine codes
localparam ST_RUN = 3'b001;
localparam ST_HALT = 3'b010;
localparam ST_WAKE = 3'b100;
localparam WK_W = 11;
// cut to the counter width on purpose; the wake count never needs more than 11 bits
localparam [31:0] WAKE_LAST_W = WAKE_CLKS - 1;
localparam [WK_W-1:0] WAKE_LAST = WAKE_LAST_W[WK_W-1:0];

// ==================================================================
// declarations
wire [6:0] pins_s;
wire main_src_s;
wire rtc_s;
wire wdt_osc_s;
wire sel_clk;
wire sel_src_rtc;
reg [2:0] state_r;
reg [2:0] state_nxt;
reg [1:0] mode_r;
reg cfg_rc_r;
reg cfg_wdt_en_r;
reg cfg_wdt_own_r;
reg [1:0] cfg_cnt_r;
reg wdt_prev_r;
reg sel_prev_r;
reg [WDT_BITS-1:0] wdt_cnt_r;
reg [WK_W-1:0] wake_cnt_r;
reg pdf_r;
reg to_r;
reg [`DCPD_IRQ_W-1:0] irq_stat_r;
reg [`DCPD_IRQ_W-1:0] irq_mask_r;
reg [`DCPD_IRQ_W-1:0] irq_set;
reg dp_wr_r;
reg [11:0] dp_addr_r;
reg [31:0] rd_nxt;
wire ap_valid;
wire dp_wr_mode;
wire dp_wr_stat;
wire dp_wr_mask;
wire sys_tick;
wire wdt_tick;
wire wdt_wrap;
wire sleep_go;
wire wake_go;
wire wake_done;

// ==================================================================
// every pin passes two flops before use
dcpd_sync2 #(.W(7)) u_sync
(
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_async({I_CFG_WDT_OWN_OSC, I_CFG_WDT_EN, I_CFG_RC_MODE, I_WDT_OSC,
        I_RTC_XTAL_IN_PIN, I_PORT_A_BIT6, I_MAIN_OSC_IN_PIN}),
    .o_sync(pins_s)
);

// ==================================================================
// options latched once after reset release; not software writable
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        cfg_cnt_r <= 2'h0;
        cfg_rc_r <= 1'b0;
        cfg_wdt_en_r <= 1'b0;
        cfg_wdt_own_r <= 1'b0;
    end
    else if (cfg_cnt_r != `DCPD_CFG_SETTLE)
    begin
        cfg_cnt_r <= cfg_cnt_r + 2'h1;
        cfg_rc_r <= pins_s[4];
        cfg_wdt_en_r <= pins_s[5];
        cfg_wdt_own_r <= pins_s[6];
    end
end

// RC mode takes the oscillator from port A bit6
assign main_src_s = cfg_rc_r ? pins_s[1] : pins_s[0];
assign rtc_s = pins_s[2];
assign wdt_osc_s = pins_s[3];

// ==================================================================
// glitch-free system clock selection
dcpd_clk_sel u_clk_sel
(
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_main_lvl(main_src_s),
    .i_rtc_lvl(rtc_s),
    .i_main_en(O_MAIN_OSC_EN),
    .i_sel_rtc(mode_r[`DCPD_MODE_SLOW_BIT]),
    .o_clk(sel_clk),
    .o_src_rtc(sel_src_rtc)
);

// ==================================================================
// edge detection on synchronised levels
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        wdt_prev_r <= 1'b0;
        sel_prev_r <= 1'b0;
    end
    else
    begin
        wdt_prev_r <= wdt_osc_s;
        sel_prev_r <= sel_clk;
    end
end

// system tick is a rising edge of the selected clock from the selector, taken ahead of the core-clock gate
assign sys_tick = sel_clk & ~sel_prev_r;
// watchdog on its own oscillator keeps ticking while halted
assign wdt_tick = cfg_wdt_own_r ? (wdt_osc_s & ~wdt_prev_r)
                                : (sys_tick & state_r[0]);
assign wdt_wrap = cfg_wdt_en_r & wdt_tick & (&wdt_cnt_r);

// ==================================================================
// power state machine
assign sleep_go = state_r[0] & I_SLEEP_EXEC;
assign wake_go = state_r[1] & (I_WAKE_REQ | wdt_wrap);
assign wake_done = state_r[2] & sys_tick & (wake_cnt_r == WAKE_LAST);

always @*
begin
    state_nxt = state_r;
    case (state_r)
        ST_RUN:
        begin
            if (sleep_go)
                state_nxt = ST_HALT;
        end
        ST_HALT:
        begin
            if (wake_go)
                state_nxt = ST_WAKE;
        end
        ST_WAKE:
        begin
            if (wake_done)
                state_nxt = ST_RUN;
        end
        default:
        begin
            state_nxt = ST_RUN;
        end
    endcase
end

// state and wake-up delay counter
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        state_r <= ST_RUN;
        wake_cnt_r <= {WK_W{1'b0}};
    end
    else
    begin
        state_r <= state_nxt;
        if (!state_r[2])
            wake_cnt_r <= {WK_W{1'b0}};
        else if (sys_tick)
            wake_cnt_r <= wake_cnt_r + {{(WK_W-1){1'b0}}, 1'b1};
    end
end

// ==================================================================
// watchdog counter; cleared by sleep or the clear instruction
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
        wdt_cnt_r <= {WDT_BITS{1'b0}};
    else if (!cfg_wdt_en_r || sleep_go || (state_r[0] && I_CLR_WDT))
        wdt_cnt_r <= {WDT_BITS{1'b0}};
    else if (wdt_tick)
        wdt_cnt_r <= wdt_cnt_r + {{(WDT_BITS-1){1'b0}}, 1'b1};
end

// ==================================================================
// status flags; hardware set wins over any clear in the same cycle
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        pdf_r <= 1'b0;
        to_r <= 1'b0;
    end
    else
    begin
        if (sleep_go)
            pdf_r <= 1'b1;
        else if (state_r[0] && I_CLR_WDT)
            pdf_r <= 1'b0;
        if (wdt_wrap)
            to_r <= 1'b1;
        else if (sleep_go)
            to_r <= 1'b0;
        else if (state_r[0] && I_CLR_WDT)
            to_r <= 1'b0;
    end
end

// ==================================================================
// ahb-lite slave, zero wait states, always OKAY
assign ap_valid = I_HSEL & I_HREADY & I_HTRANS[1];
assign dp_wr_mode = dp_wr_r & (dp_addr_r == `DCPD_OFS_MODE);
assign dp_wr_stat = dp_wr_r & (dp_addr_r == `DCPD_OFS_IRQ_STAT);
assign dp_wr_mask = dp_wr_r & (dp_addr_r == `DCPD_OFS_IRQ_MASK);

// read data prepared from the address phase, unmapped reads give zero
always @*
begin
    rd_nxt = 32'h0;
    case (I_HADDR)
        `DCPD_OFS_MODE: rd_nxt[1:0] = mode_r;
        `DCPD_OFS_STATUS: rd_nxt[7:0] = {cfg_wdt_own_r, cfg_wdt_en_r, cfg_rc_r,
            sel_src_rtc, state_r[2], state_r[1], to_r, pdf_r};
        `DCPD_OFS_IRQ_STAT: rd_nxt[`DCPD_IRQ_W-1:0] = irq_stat_r;
        `DCPD_OFS_IRQ_MASK: rd_nxt[`DCPD_IRQ_W-1:0] = irq_mask_r;
        `DCPD_OFS_WDT_CNT: rd_nxt[WDT_BITS-1:0] = wdt_cnt_r;
        default: rd_nxt = 32'h0;
    endcase
end

// address phase capture and data phase writes
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        dp_wr_r <= 1'b0;
        dp_addr_r <= 12'h0;
        O_HRDATA <= 32'h0;
        O_HREADYOUT <= 1'b1;
        O_HRESP <= 1'b0;
        mode_r <= `DCPD_MODE_RST;
        irq_mask_r <= `DCPD_IRQ_RST;
    end
    else
    begin
        O_HREADYOUT <= 1'b1;
        O_HRESP <= 1'b0;
        dp_wr_r <= ap_valid & I_HWRITE;
        if (ap_valid)
            dp_addr_r <= {I_HADDR[11:2], 2'h0};
        if (ap_valid && !I_HWRITE)
            O_HRDATA <= rd_nxt;
        // mode bits hold through power-down; only a reset or a mode register write changes them
        if (dp_wr_mode)
            mode_r <= I_HWDATA[1:0];
        if (dp_wr_mask)
            irq_mask_r <= I_HWDATA[`DCPD_IRQ_W-1:0];
    end
end

// ==================================================================
// sticky events, write one to clear; a new event beats the clear
always @*
begin
    irq_set = `DCPD_IRQ_RST;
    irq_set[`DCPD_IRQ_SLEEP_BIT] = sleep_go;
    irq_set[`DCPD_IRQ_WAKE_BIT] = wake_done;
    irq_set[`DCPD_IRQ_WDT_BIT] = wdt_wrap;
end

always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        irq_stat_r <= `DCPD_IRQ_RST;
        O_IRQ <= 1'b0;
    end
    else
    begin
        irq_stat_r <= (irq_stat_r & ~(dp_wr_stat ? I_HWDATA[`DCPD_IRQ_W-1:0]
            : `DCPD_IRQ_RST)) | irq_set;
        O_IRQ <= |(irq_stat_r & irq_mask_r);
    end
end

// ==================================================================
// oscillator controls and core-facing outputs
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        O_MAIN_OSC_EN <= 1'b1;
        O_RTC_OSC_EN <= 1'b1;
        O_RTC_QUICK_START <= 1'b1;
        O_WDT_OSC_EN <= 1'b0;
        O_PORT_A_BIT6_IS_OSC <= 1'b0;
        O_PORT_A_BIT5_IS_GPIO <= 1'b0;
        O_CORE_CLK <= 1'b0;
        O_CORE_HALT <= 1'b0;
        O_HOLD_STATE <= 1'b0;
        O_WDT_RESET <= 1'b0;
        O_POWER_DOWN_FLAG <= 1'b0;
        O_WATCHDOG_TIMEOUT_FLAG <= 1'b0;
    end
    else
    begin
        // main oscillator stops on sleep, restarts on the wake request or a watchdog wrap
        O_MAIN_OSC_EN <= ~state_nxt[1];
        // the real-time oscillator is never gated, in any mode
        O_RTC_OSC_EN <= 1'b1;
        // only the extra start-up drive follows the quick-start bit
        O_RTC_QUICK_START <= ~mode_r[`DCPD_MODE_QOFF_BIT];
        O_WDT_OSC_EN <= cfg_wdt_en_r & cfg_wdt_own_r;
        O_PORT_A_BIT6_IS_OSC <= cfg_rc_r;
        O_PORT_A_BIT5_IS_GPIO <= cfg_rc_r;
        // core clock held low while halted or waiting out the wake delay
        O_CORE_CLK <= sel_clk & state_r[0];
        O_CORE_HALT <= ~state_nxt[0];
        // core and ports freeze their contents while this is high
        O_HOLD_STATE <= ~state_nxt[0];
        O_WDT_RESET <= wdt_wrap;
        O_POWER_DOWN_FLAG <= pdf_r;
        O_WATCHDOG_TIMEOUT_FLAG <= to_r;
    end
end

endmodule // dcpd_top

// ==== tb/dcpd_chk_assertions.sv ====
// port-level assertions for the clock and power-down control
`timescale 1ns/10ps
module dcpd_chk
#(
    parameter WAKE_CLKS = 4
)
(
    // clock, reset and bus
    input wire I_SYS_CLK,
    input wire I_RST,
    input wire I_HSEL,
    input wire [11:0] I_HADDR,
    input wire [1:0] I_HTRANS,
    input wire I_HWRITE,
    input wire [31:0] I_HWDATA,
    input wire I_HREADY,
    // core and options
    input wire I_SLEEP_EXEC,
    input wire I_CFG_RC_MODE,
    input wire I_CFG_WDT_EN,
    input wire I_CFG_WDT_OWN_OSC,
    // outputs watched
    input wire O_MAIN_OSC_EN,
    input wire O_RTC_OSC_EN,
    input wire O_RTC_QUICK_START,
    input wire O_WDT_OSC_EN,
    input wire O_PORT_A_BIT6_IS_OSC,
    input wire O_PORT_A_BIT5_IS_GPIO,
    input wire O_CORE_CLK,
    input wire O_CORE_HALT,
    input wire O_HOLD_STATE,
    input wire O_WDT_RESET,
    input wire O_POWER_DOWN_FLAG,
    input wire O_WATCHDOG_TIMEOUT_FLAG
);
reg [9:0] wcnt_r;
reg mw_r;
reg qc_r;
reg qx_r;
default clocking cb @(posedge I_SYS_CLK); endclocking
default disable iff (I_RST);
// ==========
// wake length counter, and mode writes tracked to their data phase
always @(posedge I_SYS_CLK or posedge I_RST)
begin
    if (I_RST)
    begin
        wcnt_r <= 10'h0;
        mw_r <= 1'b0;
        qc_r <= 1'b0;
        qx_r <= 1'b0;
    end
    else
    begin
        // saturates so a hung wake still shows as too long
        if (!O_CORE_HALT || !O_MAIN_OSC_EN)
            wcnt_r <= 10'h0;
        else if (wcnt_r != 10'h3ff)
            wcnt_r <= wcnt_r + 10'h1;
        mw_r <= I_HSEL && I_HREADY && I_HTRANS[1] && I_HWRITE && I_HADDR[11:2] == 10'h0;
        qc_r <= mw_r;
        if (mw_r)
            qx_r <= !I_HWDATA[1];
    end
end
// ==========
// assertions
sleep_halt_a: assert property (
    I_SLEEP_EXEC && !O_CORE_HALT |=> O_CORE_HALT && !O_MAIN_OSC_EN) else $error("no halt");
halt_cause_a: assert property (
    $rose(O_CORE_HALT) |-> $past(I_SLEEP_EXEC)) else $error("halt without sleep");
pd_flags_a: assert property (
    I_SLEEP_EXEC && !O_CORE_HALT |-> ##2 O_POWER_DOWN_FLAG && !O_WATCHDOG_TIMEOUT_FLAG)
    else $error("flags wrong after sleep");
hold_a: assert property (
    O_HOLD_STATE == O_CORE_HALT && (!O_HOLD_STATE || $stable(O_RTC_QUICK_START) || $past(qc_r)))
    else $error("state not held in halt");
clk_stop_a: assert property (
    O_CORE_HALT && $past(O_CORE_HALT) |-> !O_CORE_CLK) else $error("core clock in halt");
wake_len_a: assert property (
    $fell(O_CORE_HALT) |-> wcnt_r >= WAKE_CLKS) else $error("wake delay short");
wake_bound_a: assert property (
    O_CORE_HALT |-> wcnt_r < 10'd600) else $error("wake delay hung");
rtc_on_a: assert property (
    O_RTC_OSC_EN) else $error("rtc oscillator off");
quick_a: assert property (
    qc_r |=> O_RTC_QUICK_START == qx_r) else $error("quick start wrong");
wdt_osc_a: assert property (
    O_CORE_HALT |-> O_WDT_OSC_EN == (I_CFG_WDT_EN && I_CFG_WDT_OWN_OSC))
    else $error("watchdog osc enable wrong");
rc_pins_a: assert property (
    O_CORE_HALT |-> O_PORT_A_BIT6_IS_OSC == I_CFG_RC_MODE
    && O_PORT_A_BIT5_IS_GPIO == I_CFG_RC_MODE) else $error("pin roles wrong");
wdt_to_a: assert property (
    O_WDT_RESET |-> ##[1:2] O_WATCHDOG_TIMEOUT_FLAG) else $error("timeout flag missing");
sleep_c: cover property (I_SLEEP_EXEC && !O_CORE_HALT);
wake_c: cover property ($fell(O_CORE_HALT));
wdt_c: cover property (O_WDT_RESET && O_CORE_HALT);
endmodule // dcpd_chk

// ==== tb/dcpd_osc_model.sv ====
// oscillator sources at the clock pins, periods scaled down for simulation
`timescale 1ns/10ps
module dcpd_osc_model
(
    // enables from the block
    input wire i_main_en,
    input wire i_wdt_en,
    // oscillator levels
    output reg o_main,
    output reg o_rc,
    output reg o_rtc,
    output reg o_wdt
);
initial
begin
    o_main = 1'b0;
    o_rc = 1'b0;
    o_rtc = 1'b0;
    o_wdt = 1'b0;
end
// crystal and rc stop and park low while disabled; phases unrelated to the bus clock
always #23 o_main = i_main_en ? !o_main : 1'b0;
always #37 o_rc = i_main_en ? !o_rc : 1'b0;
always #61 o_rtc = !o_rtc;
always #29 o_wdt = i_wdt_en ? !o_wdt : 1'b0;
endmodule // dcpd_osc_model

// ==== tb/dcpd_top_bench.sv ====
// self-checking bench for the clock and power-down control
`timescale 1ns/10ps
module dcpd_top_bench;
localparam WK = 4;
reg clk = 1'b0;
reg rst = 1'b1;
reg hsel = 1'b0;
reg [11:0] haddr = 12'h0;
reg [1:0] htrans = 2'h0;
reg hwrite = 1'b0;
reg [31:0] hwdata = 32'h0;
reg sleep = 1'b0;
reg wake = 1'b0;
reg clrw = 1'b0;
reg rc = 1'b0;
reg wen = 1'b0;
reg own = 1'b0;
reg [31:0] rd;
wire [31:0] hrdata;
wire hready;
wire m_osc, rc_osc, rtc_osc, wdt_osc;
wire m_en, rtc_en, qs, w_en, b6, b5, cclk, halt, hold, wrst, power_down_flag, tof, irq;
wire hresp;
integer error_cnt = 0;
integer check_count = 0;
integer n;
integer mn;
integer ed;
always #5 clk = ~clk;
dcpd_osc_model osc (.i_main_en(m_en), .i_wdt_en(w_en), .o_main(m_osc), .o_rc(rc_osc),
    .o_rtc(rtc_osc), .o_wdt(wdt_osc));
dcpd_top #(.WDT_BITS(4), .WAKE_CLKS(WK)) uut (.I_SYS_CLK(clk), .I_RST(rst), .I_HSEL(hsel),
    .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp),
    .I_MAIN_OSC_IN_PIN(m_osc), .I_PORT_A_BIT6(rc_osc), .I_RTC_XTAL_IN_PIN(rtc_osc),
    .I_WDT_OSC(wdt_osc), .I_CFG_RC_MODE(rc), .I_CFG_WDT_EN(wen), .I_CFG_WDT_OWN_OSC(own),
    .O_MAIN_OSC_EN(m_en), .O_RTC_OSC_EN(rtc_en), .O_RTC_QUICK_START(qs), .O_WDT_OSC_EN(w_en),
    .O_PORT_A_BIT6_IS_OSC(b6), .O_PORT_A_BIT5_IS_GPIO(b5), .I_SLEEP_EXEC(sleep),
    .I_WAKE_REQ(wake), .I_CLR_WDT(clrw), .O_CORE_CLK(cclk), .O_CORE_HALT(halt),
    .O_HOLD_STATE(hold), .O_WDT_RESET(wrst), .O_POWER_DOWN_FLAG(power_down_flag),
    .O_WATCHDOG_TIMEOUT_FLAG(tof), .O_IRQ(irq));
// ==========
// shared tasks
task chk(input [31:0] got, input [31:0] exp);
begin
    check_count = check_count + 1;
    if (got !== exp)
    begin
        error_cnt = error_cnt + 1;
        $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
end
endtask
task tick(input integer k);
begin
    repeat (k) @(posedge clk);
    #1;
end
endtask
// one single transfer; waits on hready, read data taken at the data-phase edge
task bus(input w, input [11:0] a, input [31:0] d);
begin
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    #1;
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
    #1;
end
endtask
// options only change while reset holds, as the design latches them after release
task do_rst(input r, input we, input ow);
begin
    rc <= r;
    wen <= we;
    own <= ow;
    rst <= 1'b1;
    tick(3);
    rst <= 1'b0;
    tick(8);
end
endtask
task slp;
begin
    sleep <= 1'b1;
    tick(1);
    sleep <= 1'b0;
end
endtask
task wt_wake;
begin
    n = 0;
    while (halt === 1'b1 && n < 800)
    begin
        tick(1);
        n = n + 1;
    end
end
endtask
// shortest high run and number of high runs of the core clock
task watch;
integer run;
begin
    mn = 99;
    ed = 0;
    run = 0;
    repeat (200)
    begin
        tick(1);
        if (cclk === 1'b1)
            run = run + 1;
        else
        begin
            if (run != 0 && run < mn)
                mn = run;
            ed = ed + (run != 0);
            run = 0;
        end
    end
end
endtask
// ==========
// scenarios
task t_reset;
begin
    do_rst(1'b0, 1'b0, 1'b0);
    chk({qs, rtc_en, m_en, halt, irq}, 5'b11100);
    bus(1'b1, 12'h020, 32'h3);
    bus(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 1'b0);
    $display("t_reset done");
end
endtask
task t_mode;
begin
    bus(1'b1, 12'h000, 32'h2);
    tick(3);
    chk({qs, rtc_en}, 2'b01);
    bus(1'b1, 12'h000, 32'h1);
    watch;
    chk(mn >= 2, 1);
    bus(1'b0, 12'h004, 32'h0);
    chk({rd[4], qs}, 2'b11);
    bus(1'b1, 12'h000, 32'h0);
    tick(60);
    bus(1'b0, 12'h004, 32'h0);
    chk(rd[4], 1'b0);
    $display("t_mode done");
end
endtask
task t_sleep;
begin
    bus(1'b1, 12'h000, 32'h2);
    bus(1'b1, 12'h00c, 32'h7);
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    tick(2);
    chk(halt, 1'b0);
    slp;
    chk({halt, hold, m_en}, 3'b110);
    tick(1);
    chk({power_down_flag, tof}, 2'b10);
    tick(3);
    chk(irq, 1'b1);
    bus(1'b1, 12'h008, 32'h1);
    bus(1'b1, 12'h00c, 32'h0);
    slp;
    tick(20);
    bus(1'b0, 12'h008, 32'h0);
    chk({rd[2:0], halt, cclk, irq}, 6'b000100);
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    wt_wake;
    chk(n >= 2 * WK, 1);
    chk({halt, power_down_flag}, 2'b01);
    bus(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h2);
    bus(1'b0, 12'h008, 32'h0);
    chk({rd[30:0], irq}, 32'h4);
    bus(1'b1, 12'h00c, 32'h2);
    tick(2);
    chk(irq, 1'b1);
    bus(1'b1, 12'h008, 32'h2);
    tick(2);
    chk(irq, 1'b0);
    clrw <= 1'b1;
    tick(1);
    clrw <= 1'b0;
    tick(3);
    chk(power_down_flag, 1'b0);
    $display("t_sleep done");
end
endtask
task t_wdt_own;
begin
    do_rst(1'b0, 1'b1, 1'b1);
    bus(1'b0, 12'h004, 32'h0);
    chk({rd[7:5], w_en}, 4'b1101);
    slp;
    tick(1);
    chk({power_down_flag, tof}, 2'b10);
    n = 0;
    while (wrst !== 1'b1 && n < 1000)
    begin
        tick(1);
        n = n + 1;
    end
    chk({wrst, halt}, 2'b11);
    tick(2);
    chk(tof, 1'b1);
    wt_wake;
    chk({halt, power_down_flag}, 2'b01);
    $display("t_wdt_own done");
end
endtask
task t_wdt_sys;
begin
    do_rst(1'b1, 1'b1, 1'b0);
    chk({b6, b5, w_en}, 3'b110);
    watch;
    chk(ed >= 5, 1);
    bus(1'b0, 12'h004, 32'h0);
    chk(rd[7:5], 3'b011);
    // clear first so a watchdog wrap cannot land on the sleep edge
    clrw <= 1'b1;
    tick(1);
    clrw <= 1'b0;
    slp;
    n = 0;
    repeat (300)
    begin
        tick(1);
        n = n + (wrst === 1'b1);
    end
    bus(1'b0, 12'h010, 32'h0);
    chk(n, 32'h0);
    chk(rd, 32'h0);
    wake <= 1'b1;
    tick(1);
    wake <= 1'b0;
    wt_wake;
    chk(halt, 1'b0);
    $display("t_wdt_sys done");
end
endtask
// ==========
// verdict, run sequence and hang guard
task close_out;
begin
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
    else
        $display("TESTS FAILED");
    $finish;
end
endtask
initial
begin
    t_reset;
    t_mode;
    t_sleep;
    t_wdt_own;
    t_wdt_sys;
    close_out;
end
initial
begin
    #300000;
    error_cnt = error_cnt + 1;
    close_out;
end
endmodule // dcpd_top_bench
bind dcpd_top dcpd_chk #(.WAKE_CLKS(WAKE_CLKS)) chk_i (.I_SYS_CLK, .I_RST, .I_HSEL, .I_HADDR,
    .I_HTRANS, .I_HWRITE, .I_HWDATA, .I_HREADY, .I_SLEEP_EXEC, .I_CFG_RC_MODE, .I_CFG_WDT_EN,
    .I_CFG_WDT_OWN_OSC, .O_MAIN_OSC_EN, .O_RTC_OSC_EN, .O_RTC_QUICK_START, .O_WDT_OSC_EN,
    .O_PORT_A_BIT6_IS_OSC, .O_PORT_A_BIT5_IS_GPIO, .O_CORE_CLK, .O_CORE_HALT, .O_HOLD_STATE,
    .O_WDT_RESET, .O_POWER_DOWN_FLAG, .O_WATCHDOG_TIMEOUT_FLAG);
